// >>> logic/wlan_key_table_control.sv
`timescale 1ns/10ps
module wlan_key_table_control #(
    // entry counts; the register map fixes both
    parameter int shared_entries   = key_table_ctrl_pkg::shared_entry_count,
    parameter int pairwise_entries = key_table_ctrl_pkg::pairwise_entry_count
) (
    // clock and reset
    input  wire logic                               sys_clk,
    input  wire logic                               reset,
    // register port
    input  wire key_table_ctrl_pkg::reg_req_t       reg_req,
    output logic [31:0]                             reg_rdata,
    output logic                                    reg_rvalid,
    // mac configuration
    input  wire logic [1:0]                         multi_bssid_mask_setting,
    // security engine query
    input  wire key_table_ctrl_pkg::frame_query_t   query,
    output key_table_ctrl_pkg::frame_answer_t       answer
);

    typedef struct packed {
        logic [31:0]                       shared_valid;
        logic [31:0]                       mode_low;
        logic [31:0]                       mode_high;
        logic [31:0]                       pw_low;
        logic [31:0]                       pw_high;
        logic [31:0]                       lookup_en;
        logic [31:0]                       rdata;
        logic                              rvalid;
        key_table_ctrl_pkg::frame_answer_t ans;
        logic [1:0]                        mask_meta;
        logic [1:0]                        mask_sync;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // the sync stages rest at one bssid so only lookup bit 0 can count before the first sample
    localparam state_t state_reset = '{
        shared_valid: key_table_ctrl_pkg::reset_value,
        mode_low:     key_table_ctrl_pkg::reset_value,
        mode_high:    key_table_ctrl_pkg::reset_value,
        pw_low:       key_table_ctrl_pkg::reset_value,
        pw_high:      key_table_ctrl_pkg::reset_value,
        lookup_en:    key_table_ctrl_pkg::reset_value,
        rdata:        key_table_ctrl_pkg::reset_value,
        rvalid:       1'b0,
        ans:          '0,
        mask_meta:    key_table_ctrl_pkg::bssid_mask_one,
        mask_sync:    key_table_ctrl_pkg::bssid_mask_one
    };

    // every flag and mode field sits at a fixed bit of a 32-bit word, so the
    // entry counts and the field layout cannot change without a new register map
    if (shared_entries != key_table_ctrl_pkg::shared_entry_count) begin : g_shared_check
        $error("shared_entries must match the register map");
    end
    if (pairwise_entries != key_table_ctrl_pkg::pairwise_entry_count) begin : g_pairwise_check
        $error("pairwise_entries must match the register map");
    end
    if (key_table_ctrl_pkg::mode_field_pitch * key_table_ctrl_pkg::modes_per_word
            != key_table_ctrl_pkg::word_width) begin : g_mode_check
        $error("mode fields must fill one word");
    end

    // code 7 collapses to none so a stray write never enables a cipher
    function automatic key_table_ctrl_pkg::cipher_t decode_cipher(input logic [2:0] code);
        key_table_ctrl_pkg::cipher_t c;
        c = key_table_ctrl_pkg::cipher_t'(code);
        if (c == key_table_ctrl_pkg::cipher_reserved) begin
            c = key_table_ctrl_pkg::cipher_none;
        end
        return c;
    endfunction

    // lookup enable is chosen from the don't-care bits per mask setting
    function automatic logic lookup_allowed(input logic [1:0] mask,
                                            input logic [1:0] dc,
                                            input logic [3:0] en);
        logic r;
        case (mask)
            key_table_ctrl_pkg::bssid_mask_one: begin
                r = en[0];
            end
            key_table_ctrl_pkg::bssid_mask_two0: begin
                r = en[{1'b0, dc[0]}];
            end
            key_table_ctrl_pkg::bssid_mask_two1: begin
                r = en[{1'b0, dc[1]}];
            end
            key_table_ctrl_pkg::bssid_mask_four: begin
                r = en[dc];
            end
            // a two-bit mask has no other value; kept so r is never left open
            default: begin
                r = 1'b0;
            end
        endcase
        return r;
    endfunction

    always_comb begin
        logic [2:0]  code;
        logic [31:0] mode_word;
        logic [4:0]  pos;
        logic        lookup_ok;
        logic [31:0] pw_word;
        logic        pw_flag;
        state_next = state_reg;
        code       = 3'h0;
        mode_word  = 32'h0;
        pos        = 5'h0;
        lookup_ok  = 1'b0;
        pw_word    = 32'h0;
        pw_flag    = 1'b0;

        // two-stage sync of the mask; only the second stage feeds the lookup.
        // the two bits may settle a cycle apart, so change the mask only while
        // no frames are being looked up
        state_next.mask_meta = multi_bssid_mask_setting;
        state_next.mask_sync = state_reg.mask_meta;

        // writes keep only defined bits
        if (reg_req.wr_en) begin
            case (reg_req.addr)
                key_table_ctrl_pkg::shared_key_valid_flags_addr: begin
                    state_next.shared_valid = reg_req.wdata
                                            & key_table_ctrl_pkg::shared_valid_mask;
                end
                key_table_ctrl_pkg::shared_key_mode_low_addr: begin
                    state_next.mode_low = reg_req.wdata
                                        & key_table_ctrl_pkg::mode_word_mask;
                end
                key_table_ctrl_pkg::shared_key_mode_high_addr: begin
                    state_next.mode_high = reg_req.wdata
                                         & key_table_ctrl_pkg::mode_word_mask;
                end
                key_table_ctrl_pkg::pairwise_valid_flags_low_addr: begin
                    state_next.pw_low = reg_req.wdata;
                end
                key_table_ctrl_pkg::pairwise_valid_flags_high_addr: begin
                    state_next.pw_high = reg_req.wdata;
                end
                key_table_ctrl_pkg::pairwise_lookup_enable_addr: begin
                    state_next.lookup_en = reg_req.wdata
                                         & key_table_ctrl_pkg::lookup_enable_mask;
                end
                default: begin
                end
            endcase
        end

        // reads return stored state; unmapped reads give zero
        // a read beside a write to the same word still returns the old value
        state_next.rvalid = reg_req.rd_en;
        state_next.rdata  = key_table_ctrl_pkg::reset_value;
        if (reg_req.rd_en) begin
            case (reg_req.addr)
                key_table_ctrl_pkg::shared_key_valid_flags_addr: begin
                    state_next.rdata = state_reg.shared_valid;
                end
                key_table_ctrl_pkg::shared_key_mode_low_addr: begin
                    state_next.rdata = state_reg.mode_low;
                end
                key_table_ctrl_pkg::shared_key_mode_high_addr: begin
                    state_next.rdata = state_reg.mode_high;
                end
                key_table_ctrl_pkg::pairwise_valid_flags_low_addr: begin
                    state_next.rdata = state_reg.pw_low;
                end
                key_table_ctrl_pkg::pairwise_valid_flags_high_addr: begin
                    state_next.rdata = state_reg.pw_high;
                end
                key_table_ctrl_pkg::pairwise_lookup_enable_addr: begin
                    state_next.rdata = state_reg.lookup_en;
                end
                default: begin
                end
            endcase
        end

        // query answer, one cycle after the query, from registered state
        mode_word = query.shared_index[3] ? state_reg.mode_high : state_reg.mode_low;
        // widen the index before scaling so entries above 1 do not wrap
        pos       = 5'(query.shared_index[2:0]) * 5'(key_table_ctrl_pkg::mode_field_pitch);
        code      = mode_word[pos +: key_table_ctrl_pkg::mode_field_width];
        state_next.ans.shared_cipher   = decode_cipher(code);
        state_next.ans.shared_valid    = state_reg.shared_valid[query.shared_index];

        // pair-wise search needs a unicast frame, a bssid hit and its enable bit
        lookup_ok = lookup_allowed(state_reg.mask_sync, query.dont_care_bits,
                                   state_reg.lookup_en[3:0]);
        pw_word   = query.pairwise_index[5] ? state_reg.pw_high : state_reg.pw_low;
        pw_flag   = pw_word[query.pairwise_index[4:0]];
        state_next.ans.pairwise_search = query.unicast_to_me & query.bssid_match
                                       & lookup_ok;
        state_next.ans.pairwise_valid  = state_next.ans.pairwise_search & pw_flag;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_reg <= state_reset;
        end else begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata  = state_reg.rdata;
    assign reg_rvalid = state_reg.rvalid;
    assign answer     = state_reg.ans;

endmodule

// >>> include/key_table_ctrl_pkg.sv
package key_table_ctrl_pkg;

    // register byte offsets
    localparam logic [15:0] shared_key_valid_flags_addr    = 16'h30a0;
    localparam logic [15:0] shared_key_mode_low_addr       = 16'h30a4;
    localparam logic [15:0] pairwise_valid_flags_low_addr  = 16'h30a8;
    localparam logic [15:0] pairwise_valid_flags_high_addr = 16'h30ac;
    localparam logic [15:0] pairwise_lookup_enable_addr    = 16'h30b0;
    localparam logic [15:0] shared_key_mode_high_addr      = 16'h30b4;

    // writable masks; everything else reads zero
    localparam logic [31:0] shared_valid_mask  = 32'h0000_ffff;
    localparam logic [31:0] mode_word_mask     = 32'h7777_7777;
    localparam logic [31:0] lookup_enable_mask = 32'h0000_000f;
    localparam logic [31:0] reset_value        = 32'h0000_0000;

    localparam int mode_field_width = 3;
    localparam int mode_field_pitch = 4;
    localparam int modes_per_word   = 8;

    // entry counts and word width fixed by the register map
    localparam int shared_entry_count   = 16;
    localparam int pairwise_entry_count = 64;
    localparam int word_width           = 32;

    // multi-bssid mask settings
    localparam logic [1:0] bssid_mask_one  = 2'h3;
    localparam logic [1:0] bssid_mask_two0 = 2'h1;
    localparam logic [1:0] bssid_mask_two1 = 2'h2;
    localparam logic [1:0] bssid_mask_four = 2'h0;

    typedef enum logic [2:0] {
        cipher_none,
        cipher_wep40,
        cipher_wep104,
        cipher_tkip,
        cipher_aes,
        cipher_ckip40,
        cipher_ckip104,
        cipher_reserved
    } cipher_t;

    typedef struct packed {
        logic        wr_en;
        logic        rd_en;
        logic [15:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic        unicast_to_me;
        logic        bssid_match;
        logic [1:0]  dont_care_bits;
        logic [3:0]  shared_index;
        logic [5:0]  pairwise_index;
    } frame_query_t;

    typedef struct packed {
        logic        pairwise_search;
        logic        shared_valid;
        cipher_t     shared_cipher;
        logic        pairwise_valid;
    } frame_answer_t;

endpackage

// >>> tb/wlan_key_table_control_props.sv
`timescale 1ns/10ps
module wlan_key_table_control_props (
    // clock and reset
    input wire logic                              sys_clk,
    input wire logic                              reset,
    // register port
    input wire key_table_ctrl_pkg::reg_req_t      reg_req,
    input wire logic [31:0]                       reg_rdata,
    input wire logic                              reg_rvalid,
    // query side
    input wire key_table_ctrl_pkg::frame_query_t  query,
    input wire key_table_ctrl_pkg::frame_answer_t answer
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    property p_rv; reg_req.rd_en |=> reg_rvalid; endproperty
    a_rv: assert property (p_rv) else $error("read not answered");
    property p_idle; !reg_req.rd_en |=> !reg_rvalid && reg_rdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data without read");
    property p_sv; reg_req.rd_en && reg_req.addr == 16'h30a0 |=> reg_rdata[31:16] == 16'h0;
    endproperty
    a_sv: assert property (p_sv) else $error("valid word high bits set");
    property p_md;
        reg_req.rd_en && (reg_req.addr == 16'h30a4 || reg_req.addr == 16'h30b4)
            |=> (reg_rdata & 32'h8888_8888) == 32'h0;
    endproperty
    a_md: assert property (p_md) else $error("mode reserved bit set");
    property p_le; reg_req.rd_en && reg_req.addr == 16'h30b0 |=> reg_rdata[31:4] == 28'h0;
    endproperty
    a_le: assert property (p_le) else $error("lookup reserved bit set");
    property p_wb;
        reg_req.wr_en && reg_req.addr == 16'h30b0 ##2 reg_req.rd_en && reg_req.addr == 16'h30b0
            |=> reg_rdata[3:0] == $past(reg_req.wdata[3:0], 3);
    endproperty
    a_wb: assert property (p_wb) else $error("lookup readback differs");
    property p_ns; !(query.unicast_to_me && query.bssid_match) |=> !answer.pairwise_search;
    endproperty
    a_ns: assert property (p_ns) else $error("search without match");
    property p_pv; answer.pairwise_valid |-> answer.pairwise_search; endproperty
    a_pv: assert property (p_pv) else $error("pairwise valid without search");
endmodule
bind wlan_key_table_control wlan_key_table_control_props u_props (.sys_clk(sys_clk),
    .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .query(query), .answer(answer));

// >>> tb/wlan_key_table_control_tb.sv
`timescale 1ns/10ps
module wlan_key_table_control_tb;
    logic                              sys_clk;
    logic                              reset;
    key_table_ctrl_pkg::reg_req_t      reg_req;
    logic [31:0]                       reg_rdata;
    logic                              reg_rvalid;
    logic [1:0]                        multi_bssid_mask_setting;
    key_table_ctrl_pkg::frame_query_t  query;
    key_table_ctrl_pkg::frame_answer_t answer;
    int                                n_mismatch;
    int                                total_checks;
    logic [15:0]                       sv;
    logic [63:0]                       md;
    logic [63:0]                       pw;
    logic [3:0]                        en;
    logic [15:0] ad [7] = '{16'h30a0, 16'h30a4, 16'h30a8, 16'h30ac, 16'h30b0, 16'h30b4, 16'h30b8};
    logic [31:0] mk [7] = '{32'hffff, 32'h77777777, 32'hffffffff, 32'hffffffff, 32'hf,
                            32'h77777777, 32'h0};
    logic [5:0]  pl [6] = '{6'h00, 6'h01, 6'h1f, 6'h20, 6'h21, 6'h3f};

    wlan_key_table_control dut (.sys_clk(sys_clk), .reset(reset), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .multi_bssid_mask_setting(multi_bssid_mask_setting), .query(query), .answer(answer));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_answer(input key_table_ctrl_pkg::frame_answer_t got,
                                input logic [5:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: answer %h expected %h", $time, got, exp);
        end
    endtask
    // an idle cycle follows every request so each strobe stays a one-cycle pulse
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_req <= '{1'b1, 1'b0, a, d};
        @(posedge sys_clk);
        reg_req <= '0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        reg_req <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge sys_clk);
        reg_req <= '0;
        #1 check(reg_rdata, e);
        check({31'h0, reg_rvalid}, 32'h1);
    endtask
    function automatic logic [5:0] ea(input logic [3:0] si, input logic s, input logic p);
        logic [2:0] c;
        c = md[si*4 +: 3];
        if (c == 3'h7) c = 3'h0;
        return {s, sv[si], c, p};
    endfunction
    function automatic logic es(input logic [1:0] m, input logic [1:0] dc);
        case (m)
            2'h3: return en[0];
            2'h1: return en[dc[0]];
            2'h2: return en[dc[1]];
            default: return en[dc];
        endcase
    endfunction
    task automatic q(input logic [1:0] um, input logic [1:0] dc, input logic [3:0] si,
                     input logic [5:0] pi, input logic s);
        @(posedge sys_clk);
        query <= '{um[1], um[0], dc, si, pi};
        @(posedge sys_clk);
        #1 check_answer(answer, ea(si, s, s & pw[pi]));
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish;
    end

    initial begin
        reset = 1'b1;
        reg_req = '0;
        multi_bssid_mask_setting = 2'h3;
        query = '0;
        sv = '0;
        md = '0;
        pw = '0;
        en = '0;
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        for (int i = 0; i < 7; i++) rd(ad[i], 32'h0);
        $display("reset values test done");
        for (int i = 0; i < 7; i++) begin
            wr(ad[i], 32'hffffffff);
            rd(ad[i], mk[i]);
        end
        $display("readback test done");
        sv = 16'ha5c3;
        md = {32'h01234567, 32'h76543210};
        wr(16'h30a0, {16'h0, sv});
        wr(16'h30a4, md[31:0]);
        wr(16'h30b4, md[63:32]);
        for (int i = 0; i < 16; i++) q(2'b01, 2'h0, i[3:0], 6'h0, 1'b0);
        $display("shared key test done");
        pw = {32'h80000002, 32'h80000001};
        wr(16'h30a8, pw[31:0]);
        wr(16'h30ac, pw[63:32]);
        wr(16'h30b0, 32'h1);
        for (int i = 0; i < 6; i++) q(2'b11, 2'h0, 4'h0, pl[i], 1'b1);
        q(2'b10, 2'h0, 4'h0, 6'h0, 1'b0);
        $display("pairwise valid test done");
        for (int m = 0; m < 4; m++) begin
            @(posedge sys_clk);
            multi_bssid_mask_setting <= m[1:0];
            for (int j = 0; j < 5; j++) begin
                en = (j == 4) ? 4'he : 4'h1 << j;
                wr(16'h30b0, {28'h0, en});
                for (int d = 0; d < 4; d++)
                    q(2'b11, d[1:0], 4'h0, 6'h0, es(m[1:0], d[1:0]));
            end
        end
        $display("lookup enable test done");
        tally_and_finish;
    end
endmodule
